// *** core/pxr_regs.sv ***
// Contract
// - First error index captured, read-only.
// - Bit 5 generation capable, resets one.
// - Bit 6 enables CRC generation, RW.
// - Bit 7 check capable, resets one.
// - Bit 8 enables CRC checking, RW.
// - Four header words of first error logged.
// - Serial header identifier reads 0x3.
// - Both headers report version 0x1.
// - Serial low word sticky, resets zero.
// - Serial high word sticky, resets zero.
// - Channel header identifier reads 0x2.
// - Channel next pointer resets zero.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pxr_regs (
    // Clock and resets.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        por_n,
    // AXI4-Lite write channels.
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Privileged configuration path for lockable fields.
    input  wire logic        priv_wr,
    input  wire logic [11:0] priv_addr,
    input  wire logic [31:0] priv_wdata,
    // Uncorrectable error report from the status logic.
    input  wire logic        err_report,
    input  wire logic [4:0]  err_index,
    input  wire logic [127:0] err_header,
    // Port controls.
    output logic             e2e_crc_gen_on,
    output logic             e2e_crc_check_on,
    output logic             irq
);

    // Sticky state, reset only by por_n.
    logic [4:0]   first_error_index_ff, nxt_first_error_index;
    logic         gen_en_ff, nxt_gen_en;
    logic         chk_en_ff, nxt_chk_en;
    logic [31:0]  hlog_ff [4], nxt_hlog [4];
    logic         logged_ff, nxt_logged;
    logic [31:0]  ser_low_ff, nxt_ser_low;
    logic [31:0]  ser_high_ff, nxt_ser_high;
    // Ordinary state, reset by aresetn.
    logic         gen_cap_ff, nxt_gen_cap;
    logic         chk_cap_ff, nxt_chk_cap;
    logic [11:0]  ser_nxt_ff, nxt_ser_nxt;
    logic [11:0]  vc_nxt_ff, nxt_vc_nxt;
    logic         unlock_ff, nxt_unlock;
    logic [1:0]   irq_st_ff, nxt_irq_st;
    logic [1:0]   irq_mask_ff, nxt_irq_mask;
    // Bus state.
    logic         aw_ff, nxt_aw;
    logic [11:0]  awaddr_ff, nxt_awaddr;
    logic         w_ff, nxt_w;
    logic [31:0]  wdata_ff, nxt_wdata;
    logic [3:0]   wstrb_ff, nxt_wstrb;
    logic         bvalid_ff, nxt_bvalid;
    logic [1:0]   bresp_ff, nxt_bresp;
    logic         rvalid_ff, nxt_rvalid;
    logic [31:0]  rdata_ff, nxt_rdata;
    logic [1:0]   rresp_ff, nxt_rresp;

    logic         wr_do;
    logic [31:0]  wmask;
    logic [31:0]  wmerge;
    logic         wr_hit;
    logic [31:0]  rd_val;
    logic         rd_hit;
    logic         lock_wr;
    logic [31:0]  lock_data;
    logic [11:0]  lock_addr;
    logic         log_now;

    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready  = !w_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign e2e_crc_gen_on   = gen_en_ff;
    assign e2e_crc_check_on = chk_en_ff;
    assign irq = |(irq_st_ff & ~irq_mask_ff);

    assign wr_do = aw_ff && w_ff && !bvalid_ff;
    assign log_now = err_report && !logged_ff;

    // Byte-lane mask built per lane.
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign wmask[i*8 +: 8] = {8{wstrb_ff[i]}};
    end

    // Lockable writes come from the privileged path, or from the bus when unlocked.
    always_comb begin
        lock_wr   = priv_wr;
        lock_addr = priv_addr;
        lock_data = priv_wdata;
        if (!priv_wr && wr_do && unlock_ff) begin
            lock_wr   = 1'b1;
            lock_addr = awaddr_ff;
            lock_data = wmerge;
        end
    end

    // Read decode; reserved bits return zero.
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            pxr_pkg::OFF_ERR_CTRL: begin
                rd_val[pxr_pkg::FEI_LSB +: pxr_pkg::FEI_W] = first_error_index_ff;
                rd_val[pxr_pkg::GEN_CAP] = gen_cap_ff;
                rd_val[pxr_pkg::GEN_EN]  = gen_en_ff;
                rd_val[pxr_pkg::CHK_CAP] = chk_cap_ff;
                rd_val[pxr_pkg::CHK_EN]  = chk_en_ff;
            end
            pxr_pkg::OFF_HLOG1: rd_val = hlog_ff[0];
            pxr_pkg::OFF_HLOG2: rd_val = hlog_ff[1];
            pxr_pkg::OFF_HLOG3: rd_val = hlog_ff[2];
            pxr_pkg::OFF_HLOG4: rd_val = hlog_ff[3];
            pxr_pkg::OFF_SER_HDR: begin
                rd_val[pxr_pkg::CAPABILITY_IDENTIFIER_LSB +: 16] = pxr_pkg::SER_CAPABILITY_IDENTIFIER;
                rd_val[pxr_pkg::CAPABILITY_VERSION_LSB +: 4] = pxr_pkg::CAP_VERSION;
                rd_val[pxr_pkg::NXT_LSB +: 12]   = ser_nxt_ff;
            end
            pxr_pkg::OFF_SER_LOW:  rd_val = ser_low_ff;
            pxr_pkg::OFF_SER_HIGH: rd_val = ser_high_ff;
            pxr_pkg::OFF_VC_HDR: begin
                rd_val[pxr_pkg::CAPABILITY_IDENTIFIER_LSB +: 16] = pxr_pkg::VC_CAPABILITY_IDENTIFIER;
                rd_val[pxr_pkg::CAPABILITY_VERSION_LSB +: 4] = pxr_pkg::CAP_VERSION;
                rd_val[pxr_pkg::NXT_LSB +: 12]   = vc_nxt_ff;
            end
            pxr_pkg::OFF_PRIV_CTRL:  rd_val[pxr_pkg::PRIV_UNLOCK] = unlock_ff;
            pxr_pkg::OFF_IRQ_STATUS: rd_val[pxr_pkg::IRQ_W-1:0] = irq_st_ff;
            pxr_pkg::OFF_IRQ_MASK:   rd_val[pxr_pkg::IRQ_W-1:0] = irq_mask_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    // Current value of a lockable register merged with the strobed bytes; other registers take the strobed bytes alone.
    always_comb begin
        wr_hit = 1'b1;
        wmerge = 32'h0000_0000;
        unique case (awaddr_ff)
            pxr_pkg::OFF_HLOG1, pxr_pkg::OFF_HLOG2, pxr_pkg::OFF_HLOG3,
            pxr_pkg::OFF_HLOG4, pxr_pkg::OFF_PRIV_CTRL, pxr_pkg::OFF_IRQ_STATUS,
            pxr_pkg::OFF_IRQ_MASK: wmerge = wdata_ff & wmask;
            // Lockable fields keep their bits in lanes that are not strobed.
            pxr_pkg::OFF_ERR_CTRL: begin
                wmerge = wdata_ff & wmask;
                if (!wstrb_ff[0]) begin
                    wmerge[pxr_pkg::GEN_CAP] = gen_cap_ff;
                    wmerge[pxr_pkg::CHK_CAP] = chk_cap_ff;
                end
            end
            pxr_pkg::OFF_SER_HDR:
                wmerge = (wdata_ff & wmask) | ({ser_nxt_ff, 20'h0_0000} & ~wmask);
            pxr_pkg::OFF_VC_HDR:
                wmerge = (wdata_ff & wmask) | ({vc_nxt_ff, 20'h0_0000} & ~wmask);
            pxr_pkg::OFF_SER_LOW:  wmerge = (wdata_ff & wmask) | (ser_low_ff & ~wmask);
            pxr_pkg::OFF_SER_HIGH: wmerge = (wdata_ff & wmask) | (ser_high_ff & ~wmask);
            default: wr_hit = 1'b0;
        endcase
    end

    // Bus handshake.
    always_comb begin
        nxt_aw     = aw_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w      = w_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw     = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w     = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (wr_do) begin
            nxt_aw     = 1'b0;
            nxt_w      = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = wr_hit ? pxr_pkg::RESP_OKAY : pxr_pkg::RESP_SLVERR;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = rd_val;
            nxt_rresp  = rd_hit ? pxr_pkg::RESP_OKAY : pxr_pkg::RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // Register updates.
    always_comb begin
        nxt_first_error_index = first_error_index_ff;
        nxt_gen_en   = gen_en_ff;
        nxt_chk_en   = chk_en_ff;
        nxt_hlog     = hlog_ff;
        nxt_logged   = logged_ff;
        nxt_ser_low  = ser_low_ff;
        nxt_ser_high = ser_high_ff;
        nxt_gen_cap  = gen_cap_ff;
        nxt_chk_cap  = chk_cap_ff;
        nxt_ser_nxt  = ser_nxt_ff;
        nxt_vc_nxt   = vc_nxt_ff;
        nxt_unlock   = unlock_ff;
        nxt_irq_st   = irq_st_ff;
        nxt_irq_mask = irq_mask_ff;
        if (wr_do && awaddr_ff == pxr_pkg::OFF_ERR_CTRL && wstrb_ff[0]) begin
            nxt_gen_en = wdata_ff[pxr_pkg::GEN_EN];
        end
        if (wr_do && awaddr_ff == pxr_pkg::OFF_ERR_CTRL && wstrb_ff[1]) begin
            nxt_chk_en = wdata_ff[pxr_pkg::CHK_EN];
        end
        if (wr_do && awaddr_ff == pxr_pkg::OFF_PRIV_CTRL && wstrb_ff[0]) begin
            nxt_unlock = wdata_ff[pxr_pkg::PRIV_UNLOCK];
        end
        if (wr_do && awaddr_ff == pxr_pkg::OFF_IRQ_MASK) begin
            nxt_irq_mask = wmerge[pxr_pkg::IRQ_W-1:0];
        end
        if (wr_do && awaddr_ff == pxr_pkg::OFF_IRQ_STATUS) begin
            nxt_irq_st = irq_st_ff & ~wmerge[pxr_pkg::IRQ_W-1:0];
        end
        if (lock_wr) begin
            unique case (lock_addr)
                pxr_pkg::OFF_ERR_CTRL: begin
                    nxt_gen_cap = lock_data[pxr_pkg::GEN_CAP];
                    nxt_chk_cap = lock_data[pxr_pkg::CHK_CAP];
                end
                pxr_pkg::OFF_SER_HDR:  nxt_ser_nxt  = lock_data[pxr_pkg::NXT_LSB +: 12];
                pxr_pkg::OFF_VC_HDR:   nxt_vc_nxt   = lock_data[pxr_pkg::NXT_LSB +: 12];
                pxr_pkg::OFF_SER_LOW:  nxt_ser_low  = lock_data;
                pxr_pkg::OFF_SER_HIGH: nxt_ser_high = lock_data;
                default: ;
            endcase
            if (lock_addr == pxr_pkg::OFF_SER_LOW || lock_addr == pxr_pkg::OFF_SER_HIGH) begin
                nxt_irq_st[pxr_pkg::IRQ_SER_WR] = 1'b1;
            end
        end
        // Only the first report is logged until power-on reset re-arms it.
        if (log_now) begin
            nxt_first_error_index = err_index;
            nxt_logged = 1'b1;
            nxt_irq_st[pxr_pkg::IRQ_FIRST_ERR] = 1'b1;
            for (int k = 0; k < 4; k++) begin
                nxt_hlog[k] = err_header[k*32 +: 32];
            end
        end
    end

    // Sticky flops, cleared only by power-on reset.
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            first_error_index_ff <= 5'h00;
            gen_en_ff    <= 1'b0;
            chk_en_ff    <= 1'b0;
            logged_ff    <= 1'b0;
            ser_low_ff   <= pxr_pkg::WORD_RST;
            ser_high_ff  <= pxr_pkg::WORD_RST;
            for (int k = 0; k < 4; k++) begin
                hlog_ff[k] <= pxr_pkg::WORD_RST;
            end
        end else begin
            first_error_index_ff <= nxt_first_error_index;
            gen_en_ff    <= nxt_gen_en;
            chk_en_ff    <= nxt_chk_en;
            logged_ff    <= nxt_logged;
            ser_low_ff   <= nxt_ser_low;
            ser_high_ff  <= nxt_ser_high;
            hlog_ff      <= nxt_hlog;
        end
    end

    // Ordinary flops.
    always_ff @(posedge aclk) begin
        if (!aresetn || !por_n) begin
            gen_cap_ff  <= pxr_pkg::GEN_CAP_RST;
            chk_cap_ff  <= pxr_pkg::CHK_CAP_RST;
            ser_nxt_ff  <= pxr_pkg::NXT_RESET;
            vc_nxt_ff   <= pxr_pkg::NXT_RESET;
            unlock_ff   <= 1'b0;
            irq_st_ff   <= 2'b00;
            irq_mask_ff <= 2'b00;
            aw_ff       <= 1'b0;
            awaddr_ff   <= 12'h000;
            w_ff        <= 1'b0;
            wdata_ff    <= 32'h0000_0000;
            wstrb_ff    <= 4'h0;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= 2'b00;
            rvalid_ff   <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            rresp_ff    <= 2'b00;
        end else begin
            gen_cap_ff  <= nxt_gen_cap;
            chk_cap_ff  <= nxt_chk_cap;
            ser_nxt_ff  <= nxt_ser_nxt;
            vc_nxt_ff   <= nxt_vc_nxt;
            unlock_ff   <= nxt_unlock;
            irq_st_ff   <= nxt_irq_st;
            irq_mask_ff <= nxt_irq_mask;
            aw_ff       <= nxt_aw;
            awaddr_ff   <= nxt_awaddr;
            w_ff        <= nxt_w;
            wdata_ff    <= nxt_wdata;
            wstrb_ff    <= nxt_wstrb;
            bvalid_ff   <= nxt_bvalid;
            bresp_ff    <= nxt_bresp;
            rvalid_ff   <= nxt_rvalid;
            rdata_ff    <= nxt_rdata;
            rresp_ff    <= nxt_rresp;
        end
    end

endmodule : pxr_regs
`default_nettype wire

// *** include/pxr_pkg.sv ***
package pxr_pkg;

    // Register byte addresses.
    localparam logic [11:0] OFF_ERR_CTRL    = 12'h118;
    localparam logic [11:0] OFF_HLOG1       = 12'h11c;
    localparam logic [11:0] OFF_HLOG2       = 12'h120;
    localparam logic [11:0] OFF_HLOG3       = 12'h124;
    localparam logic [11:0] OFF_HLOG4       = 12'h128;
    localparam logic [11:0] OFF_SER_HDR     = 12'h180;
    localparam logic [11:0] OFF_SER_LOW     = 12'h184;
    localparam logic [11:0] OFF_SER_HIGH    = 12'h188;
    localparam logic [11:0] OFF_VC_HDR      = 12'h200;
    localparam logic [11:0] OFF_PRIV_CTRL   = 12'h300;
    localparam logic [11:0] OFF_IRQ_STATUS  = 12'h304;
    localparam logic [11:0] OFF_IRQ_MASK    = 12'h308;

    // Error control word fields.
    localparam int FEI_LSB   = 0;
    localparam int FEI_W     = 5;
    localparam int GEN_CAP   = 5;
    localparam int GEN_EN    = 6;
    localparam int CHK_CAP   = 7;
    localparam int CHK_EN    = 8;

    // Capability header fields.
    localparam int CAPABILITY_IDENTIFIER_LSB = 0;
    localparam int CAPABILITY_VERSION_LSB = 16;
    localparam int NXT_LSB   = 20;
    localparam logic [15:0] SER_CAPABILITY_IDENTIFIER  = 16'h0003;
    localparam logic [15:0] VC_CAPABILITY_IDENTIFIER   = 16'h0002;
    localparam logic [3:0]  CAP_VERSION = 4'h1;
    localparam logic [11:0] NXT_RESET  = 12'h000;

    // Reset values.
    localparam logic        GEN_CAP_RST = 1'b1;
    localparam logic        CHK_CAP_RST = 1'b1;
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;

    // Private control: bit 0 unlocks lockable fields for ordinary writes.
    localparam int PRIV_UNLOCK = 0;

    // Interrupt status bits.
    localparam int IRQ_W         = 2;
    localparam int IRQ_FIRST_ERR = 0;
    localparam int IRQ_SER_WR    = 1;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : pxr_pkg

// *** testbench/pxr_regs_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module pxr_regs_asserts (
    // Clock and resets.
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        por_n,
    // Bus signals watched.
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Port controls.
    input wire logic        e2e_crc_gen_on,
    input wire logic        e2e_crc_check_on
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !por_n);
    sequence s_rd(logic [11:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    property p_vc_hdr;
        s_rd(pxr_pkg::OFF_VC_HDR) |=> s_axi_rvalid && s_axi_rdata[15:0] == pxr_pkg::VC_CAPABILITY_IDENTIFIER
            && s_axi_rdata[19:16] == pxr_pkg::CAP_VERSION;
    endproperty
    a_vc_hdr: assert property (p_vc_hdr) else $error("channel header wrong");
    property p_ser_hdr;
        s_rd(pxr_pkg::OFF_SER_HDR) |=> s_axi_rvalid && s_axi_rdata[15:0] == pxr_pkg::SER_CAPABILITY_IDENTIFIER
            && s_axi_rdata[19:16] == pxr_pkg::CAP_VERSION;
    endproperty
    a_ser_hdr: assert property (p_ser_hdr) else $error("serial header wrong");
    property p_ctrl_rsvd;
        s_rd(pxr_pkg::OFF_ERR_CTRL) |=> s_axi_rdata[31:9] == 23'h00_0000;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bits set");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h400 |=> s_axi_rvalid
            && s_axi_rresp == pxr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_gen_on;
        $changed(e2e_crc_gen_on) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
            || $past(s_axi_wvalid, 3);
    endproperty
    a_gen_on: assert property (p_gen_on) else $error("generate enable moved alone");
    property p_chk_on;
        $changed(e2e_crc_check_on) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
            || $past(s_axi_wvalid, 3);
    endproperty
    a_chk_on: assert property (p_chk_on) else $error("check enable moved alone");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
            && $stable(s_axi_rresp);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_ar_block;
        (s_axi_rvalid |-> !s_axi_arready) and (s_axi_bvalid |-> !s_axi_awready);
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("request taken while busy");
endmodule : pxr_regs_asserts
bind pxr_regs pxr_regs_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .e2e_crc_gen_on(e2e_crc_gen_on), .e2e_crc_check_on(e2e_crc_check_on));
`default_nettype wire

// *** testbench/pxr_regs_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module pxr_regs_test;
    logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, pwr = 1'b0, erep = 1'b0;
    logic [11:0] awa = '0, ara = '0, pa = '0;
    logic [31:0] wd = '0, pd = '0, rd;
    logic [3:0] ws = '0;
    logic [4:0] eix = '0;
    logic [127:0] ehd = '0, h;
    logic awr, wr_rdy, bv, arr, rv, gen_on, chk_on, irq;
    logic [1:0] br, rr;
    int error_cnt = 0, checked = 0;
    always #20 aclk = ~aclk;
    pxr_regs u_dut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .priv_wr(pwr), .priv_addr(pa), .priv_wdata(pd),
        .err_report(erep), .err_index(eix), .err_header(ehd),
        .e2e_crc_gen_on(gen_on), .e2e_crc_check_on(chk_on), .irq(irq));
    // The ready is raised only once the answer is seen, so every answer stalls one cycle.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        @(posedge aclk);
        awa <= a; wd <= d; ws <= s; awv <= 1'b1; wv <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_rdy) wv <= 1'b0;
            if (bv && bry) begin
                r = br;
                bry <= 1'b0;
                break;
            end
            if (bv) bry <= 1'b1;
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        ara <= a; arv <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
            if (rv && rry) begin
                d = rd; r = rr;
                rry <= 1'b0;
                break;
            end
            if (rv) rry <= 1'b1;
        end
    endtask : axi_rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        axi_wr(a, d, s, r);
        `CHK("bresp", pxr_pkg::RESP_OKAY, r)
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        `CHK(nm, e, d)
        `CHK("rresp", pxr_pkg::RESP_OKAY, r)
    endtask : rd_chk
    task automatic outs_chk(input logic g, input logic c, input logic i);
        @(negedge aclk);
        `CHK("gen_on", g, gen_on)
        `CHK("chk_on", c, chk_on)
        `CHK("irq", i, irq)
    endtask : outs_chk
    task automatic pulse_rst(input logic full);
        @(posedge aclk);
        aresetn <= 1'b0;
        por_n <= !full;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
    endtask : pulse_rst
    task automatic t_defaults;
        rd_chk(pxr_pkg::OFF_ERR_CTRL, 32'h0000_00a0, "ctrl");
        for (int i = 0; i < 4; i++) rd_chk(pxr_pkg::OFF_HLOG1 + 12'(4 * i), '0, "hlog");
        rd_chk(pxr_pkg::OFF_SER_HDR, 32'h0001_0003, "ser_hdr");
        rd_chk(pxr_pkg::OFF_SER_LOW, '0, "ser_low");
        rd_chk(pxr_pkg::OFF_SER_HIGH, '0, "ser_high");
        rd_chk(pxr_pkg::OFF_VC_HDR, 32'h0001_0002, "vc_hdr");
    endtask : t_defaults
    task automatic t_ctrl;
        wr(pxr_pkg::OFF_ERR_CTRL, 32'hffff_ffff, 4'hf);
        rd_chk(pxr_pkg::OFF_ERR_CTRL, 32'h0000_01e0, "ctrl_set");
        outs_chk(1'b1, 1'b1, 1'b0);
        wr(pxr_pkg::OFF_ERR_CTRL, 32'h0000_0000, 4'h2);
        outs_chk(1'b1, 1'b0, 1'b0);
        wr(pxr_pkg::OFF_ERR_CTRL, 32'h0000_0000, 4'hf);
        rd_chk(pxr_pkg::OFF_ERR_CTRL, 32'h0000_00a0, "ctrl_clr");
    endtask : t_ctrl
    task automatic t_err_log;
        h = {32'h4444_0004, 32'h3333_0003, 32'h2222_0002, 32'h1111_0001};
        @(posedge aclk);
        erep <= 1'b1; eix <= 5'h13; ehd <= h;
        @(posedge aclk);
        erep <= 1'b1; eix <= 5'h04; ehd <= ~h;
        @(posedge aclk);
        erep <= 1'b0;
        rd_chk(pxr_pkg::OFF_ERR_CTRL, 32'h0000_00b3, "first_idx");
        for (int i = 0; i < 4; i++) begin
            rd_chk(pxr_pkg::OFF_HLOG1 + 12'(4 * i), h[32*i +: 32], "hlog");
        end
        outs_chk(1'b0, 1'b0, 1'b1);
        wr(pxr_pkg::OFF_IRQ_MASK, 32'h0000_0001, 4'hf);
        outs_chk(1'b0, 1'b0, 1'b0);
        wr(pxr_pkg::OFF_IRQ_MASK, 32'h0000_0000, 4'hf);
        wr(pxr_pkg::OFF_IRQ_STATUS, 32'h0000_0001, 4'hf);
        outs_chk(1'b0, 1'b0, 1'b0);
    endtask : t_err_log
    task automatic t_serial;
        logic [1:0] r;
        wr(pxr_pkg::OFF_SER_LOW, 32'hffff_ffff, 4'hf);
        rd_chk(pxr_pkg::OFF_SER_LOW, '0, "ser_locked");
        @(posedge aclk);
        pwr <= 1'b1; pa <= pxr_pkg::OFF_SER_HIGH; pd <= 32'h0a0b_0c0d;
        @(posedge aclk);
        pa <= pxr_pkg::OFF_VC_HDR; pd <= 32'h1230_0000;
        @(posedge aclk);
        pwr <= 1'b0;
        rd_chk(pxr_pkg::OFF_SER_HIGH, 32'h0a0b_0c0d, "ser_high");
        rd_chk(pxr_pkg::OFF_VC_HDR, 32'h1231_0002, "vc_locked");
        outs_chk(1'b0, 1'b0, 1'b1);
        wr(pxr_pkg::OFF_PRIV_CTRL, 32'h0000_0001, 4'hf);
        wr(pxr_pkg::OFF_SER_LOW, 32'h1234_5678, 4'hf);
        wr(pxr_pkg::OFF_PRIV_CTRL, 32'h0000_0000, 4'hf);
        rd_chk(pxr_pkg::OFF_SER_LOW, 32'h1234_5678, "ser_low");
        wr(pxr_pkg::OFF_IRQ_STATUS, 32'h0000_0003, 4'hf);
        outs_chk(1'b0, 1'b0, 1'b0);
        axi_wr(12'h400, 32'hffff_ffff, 4'hf, r);
        `CHK("bresp_unmapped", pxr_pkg::RESP_SLVERR, r)
        axi_rd(12'h400, h[31:0], r);
        `CHK("rresp_unmapped", pxr_pkg::RESP_SLVERR, r)
    endtask : t_serial
    task automatic t_sticky;
        wr(pxr_pkg::OFF_ERR_CTRL, 32'h0000_0140, 4'h3);
        pulse_rst(1'b0);
        outs_chk(1'b1, 1'b1, 1'b0);
        rd_chk(pxr_pkg::OFF_ERR_CTRL, 32'h0000_01f3, "ctrl_kept");
        rd_chk(pxr_pkg::OFF_HLOG4, 32'h4444_0004, "hlog_kept");
        rd_chk(pxr_pkg::OFF_SER_LOW, 32'h1234_5678, "ser_kept");
        rd_chk(pxr_pkg::OFF_VC_HDR, 32'h0001_0002, "vc_rst");
        pulse_rst(1'b1);
        outs_chk(1'b0, 1'b0, 1'b0);
        rd_chk(pxr_pkg::OFF_SER_HIGH, '0, "ser_por");
        t_defaults();
    endtask : t_sticky
    task automatic close_out;
        $display("errors %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        t_defaults();
        t_ctrl();
        t_err_log();
        t_serial();
        t_sticky();
        close_out();
    end
endmodule : pxr_regs_test
`default_nettype wire
